// *** logic/ocd_pkg.sv ***
/*
  Shared types and constants for the opcode decode and timing block:
  instruction classes, the decoded-instruction record, byte lengths and
  cycle counts. Assumes one machine cycle equals one ref_clk period.
*/
package ocd_pkg;

  // One machine cycle is one clock period
  localparam int unsigned CLK_PERIOD_NS = 100;

  localparam int unsigned OPC_W = 8;
  localparam int unsigned LEN_W = 2;
  localparam int unsigned CYC_W = 5;
  localparam int unsigned DATA_W = 8;

  // Instruction byte lengths
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Machine cycle counts
  localparam logic [4:0] CYC_1 = 5'h01;
  localparam logic [4:0] CYC_2 = 5'h02;
  localparam logic [4:0] CYC_3 = 5'h03;
  localparam logic [4:0] CYC_4 = 5'h04;
  localparam logic [4:0] CYC_5 = 5'h05;
  localparam logic [4:0] CYC_6 = 5'h06;
  localparam logic [4:0] CYC_7 = 5'h07;
  localparam logic [4:0] CYC_8 = 5'h08;
  localparam logic [4:0] CYC_MULDIV_8 = 5'h0B;
  localparam logic [4:0] CYC_MULDIV_16 = 5'h14;

  // Reset values and the count of the last cycle
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] CNT_IDLE = 5'h00;
  localparam logic [4:0] CNT_LAST = 5'h01;

  typedef enum logic [3:0] {
    OCD_ARITH,
    OCD_LOGIC,
    OCD_ROTATE,
    OCD_MOVE,
    OCD_CODE_READ,
    OCD_XDATA,
    OCD_STACK,
    OCD_EXCH,
    OCD_NIBBLE,
    OCD_MULDIV,
    OCD_OTHER
  } ocd_class_e;

  typedef struct packed {
    logic       known;
    ocd_class_e cls;
    logic [1:0] len;
    logic [4:0] cyc;
  } ocd_dec_s;

endpackage

// *** logic/ocd_decode.sv ***
/*
  Opcode decoder and execution-length sequencer for the pipelined 8-bit
  core. Decodes arithmetic, logic, rotate, move, stack, exchange and
  external-data-move opcodes into byte length, cycle count and class,
  holds the instruction for its cycle count and performs the accumulator
  rotates, nibble swap and low nibble exchange.
  Assumes the fetch unit presents one opcode at a time with op_valid,
  all inputs synchronous to ref_clk, and an operand byte from the
  pointer_register target on ind_data when the opcode is taken.
*/
`timescale 1ns/1ps

module ocd_decode (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // Opcode fetch
  input  wire logic                op_valid,
  input  wire logic [7:0]          opcode,
  input  wire logic                wide_operand,
  // Accumulator load from the core
  input  wire logic                acc_load,
  input  wire logic [7:0]          acc_in,
  // Operand byte addressed by the pointer register
  input  wire logic [7:0]          ind_data,
  // Decoded instruction and timing
  output ocd_pkg::ocd_dec_s        dec_info,
  output logic                     busy,
  output logic                     last_cycle,
  // Accumulator state
  output logic [7:0]               acc,
  output logic                     carry,
  // Write-back of the exchanged memory byte
  output logic [7:0]               nib_wdata,
  output logic                     nib_we
);

  logic               rst_meta;
  logic               rst_sync_b;
  logic [4:0]         cnt;
  logic [4:0]         next_cnt;
  logic               accept;
  ocd_pkg::ocd_dec_s  dec_now;
  ocd_pkg::ocd_dec_s  held;

  // Reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // Opcode table: byte length, cycle count and class
  function automatic ocd_pkg::ocd_dec_s decode(input logic [7:0] op,
                                              input logic       wide);
    ocd_pkg::ocd_dec_s d;
    d.known = 1'b1;
    d.cls   = ocd_pkg::OCD_OTHER;
    d.len   = ocd_pkg::LEN_1;
    d.cyc   = ocd_pkg::CYC_1;
    unique casez (op)
      // Add, add with carry, subtract with borrow
      8'b0010_1???, 8'b0011_1???, 8'b1001_1???: begin
        d.cls = ocd_pkg::OCD_ARITH;
      end
      8'h25, 8'h24, 8'h35, 8'h34, 8'h95, 8'h94: begin
        d.cls = ocd_pkg::OCD_ARITH;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_2;
      end
      8'b0010_011?, 8'b0011_011?, 8'b1001_011?: begin
        d.cls = ocd_pkg::OCD_ARITH;
        d.cyc = ocd_pkg::CYC_2;
      end
      // Increment and decrement
      8'h04, 8'h14: begin
        d.cls = ocd_pkg::OCD_ARITH;
      end
      8'b0000_1???, 8'b0001_1???: begin
        d.cls = ocd_pkg::OCD_ARITH;
        d.cyc = ocd_pkg::CYC_2;
      end
      8'h05, 8'h15: begin
        d.cls = ocd_pkg::OCD_ARITH;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_3;
      end
      8'b0000_011?, 8'b0001_011?: begin
        d.cls = ocd_pkg::OCD_ARITH;
        d.cyc = ocd_pkg::CYC_3;
      end
      8'hA3: begin
        d.cls = ocd_pkg::OCD_ARITH;
        d.cyc = ocd_pkg::CYC_4;
      end
      // Multiply and divide, decimal adjust, accumulator clear and complement
      8'hA4, 8'h84: begin
        d.cls = ocd_pkg::OCD_MULDIV;
        d.cyc = wide ? ocd_pkg::CYC_MULDIV_16 : ocd_pkg::CYC_MULDIV_8;
      end
      8'hD4, 8'hE4, 8'hF4: begin
        d.cls = ocd_pkg::OCD_ARITH;
      end
      // AND, OR, XOR into the accumulator
      8'b0101_1???, 8'b0100_1???, 8'b0110_1???: begin
        d.cls = ocd_pkg::OCD_LOGIC;
      end
      8'h55, 8'h54, 8'h45, 8'h44, 8'h65, 8'h64: begin
        d.cls = ocd_pkg::OCD_LOGIC;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_2;
      end
      8'b0101_011?, 8'b0100_011?, 8'b0110_011?: begin
        d.cls = ocd_pkg::OCD_LOGIC;
        d.cyc = ocd_pkg::CYC_2;
      end
      // AND, OR, XOR into a direct byte
      8'h52, 8'h42, 8'h62: begin
        d.cls = ocd_pkg::OCD_LOGIC;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_3;
      end
      8'h53, 8'h43, 8'h63: begin
        d.cls = ocd_pkg::OCD_LOGIC;
        d.len = ocd_pkg::LEN_3;
        d.cyc = ocd_pkg::CYC_3;
      end
      // Rotates and nibble swap
      8'h23, 8'h33, 8'h03, 8'h13: begin
        d.cls = ocd_pkg::OCD_ROTATE;
      end
      8'hC4: begin
        d.cls = ocd_pkg::OCD_ROTATE;
        d.cyc = ocd_pkg::CYC_4;
      end
      // Loads into the accumulator
      8'b1110_1???: begin
        d.cls = ocd_pkg::OCD_MOVE;
      end
      8'hE5, 8'h74: begin
        d.cls = ocd_pkg::OCD_MOVE;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_2;
      end
      8'b1110_011?: begin
        d.cls = ocd_pkg::OCD_MOVE;
        d.cyc = ocd_pkg::CYC_2;
      end
      // Loads into a working register
      8'b1111_1???, 8'b1111_011?: begin
        d.cls = ocd_pkg::OCD_MOVE;
        d.cyc = ocd_pkg::CYC_2;
      end
      8'b1010_1???, 8'b1010_011?, 8'b1000_011?: begin
        d.cls = ocd_pkg::OCD_MOVE;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_3;
      end
      8'b0111_1???, 8'b0111_011?, 8'b1000_1???, 8'hF5: begin
        d.cls = ocd_pkg::OCD_MOVE;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_2;
      end
      8'h85, 8'h75, 8'h90: begin
        d.cls = ocd_pkg::OCD_MOVE;
        d.len = ocd_pkg::LEN_3;
        d.cyc = ocd_pkg::CYC_3;
      end
      // Code memory reads
      8'h93: begin
        d.cls = ocd_pkg::OCD_CODE_READ;
        d.cyc = ocd_pkg::CYC_7;
      end
      8'h83: begin
        d.cls = ocd_pkg::OCD_CODE_READ;
        d.cyc = ocd_pkg::CYC_8;
      end
      // External data moves
      8'b1110_001?: begin
        d.cls = ocd_pkg::OCD_XDATA;
        d.cyc = ocd_pkg::CYC_5;
      end
      8'hE0: begin
        d.cls = ocd_pkg::OCD_XDATA;
        d.cyc = ocd_pkg::CYC_6;
      end
      8'b1111_001?: begin
        d.cls = ocd_pkg::OCD_XDATA;
        d.cyc = ocd_pkg::CYC_4;
      end
      8'hF0: begin
        d.cls = ocd_pkg::OCD_XDATA;
        d.cyc = ocd_pkg::CYC_5;
      end
      // Stack
      8'hC0: begin
        d.cls = ocd_pkg::OCD_STACK;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_5;
      end
      8'hD0: begin
        d.cls = ocd_pkg::OCD_STACK;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_4;
      end
      // Exchanges
      8'b1100_1???: begin
        d.cls = ocd_pkg::OCD_EXCH;
        d.cyc = ocd_pkg::CYC_3;
      end
      8'hC5: begin
        d.cls = ocd_pkg::OCD_EXCH;
        d.len = ocd_pkg::LEN_2;
        d.cyc = ocd_pkg::CYC_4;
      end
      8'b1100_011?: begin
        d.cls = ocd_pkg::OCD_EXCH;
        d.cyc = ocd_pkg::CYC_4;
      end
      8'b1101_011?: begin
        d.cls = ocd_pkg::OCD_NIBBLE;
        d.cyc = ocd_pkg::CYC_4;
      end
      // Branches, bit operations and others are outside this block
      default: begin
        d.known = 1'b0;
      end
    endcase
    return d;
  endfunction

  assign dec_now = decode(opcode, wide_operand);

  // A new opcode is taken when idle or in the last cycle of the current one
  assign accept = op_valid && (cnt == ocd_pkg::CNT_IDLE ||
                               cnt == ocd_pkg::CNT_LAST);

  always_comb begin
    if (accept) begin
      next_cnt = dec_now.cyc;
    end else if (cnt != ocd_pkg::CNT_IDLE) begin
      next_cnt = cnt - ocd_pkg::CNT_LAST;
    end else begin
      next_cnt = ocd_pkg::CNT_IDLE;
    end
  end

  // Cycle counter and timing flags
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt        <= ocd_pkg::CNT_IDLE;
      busy       <= 1'b0;
      last_cycle <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      busy       <= next_cnt != ocd_pkg::CNT_IDLE;
      last_cycle <= next_cnt == ocd_pkg::CNT_LAST;
    end
  end

  // Decoded record held for the whole instruction
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      held <= '0;
    end else if (accept) begin
      held <= dec_now;
    end
  end

  assign dec_info = held;

  // Accumulator and carry effects of rotates, swaps and clears
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      acc   <= ocd_pkg::ACC_RST;
      carry <= 1'b0;
    end else if (accept) begin
      unique casez (opcode)
        8'h23: acc <= {acc[6:0], acc[7]};
        8'h33: begin
          acc   <= {acc[6:0], carry};
          carry <= acc[7];
        end
        8'h03: acc <= {acc[0], acc[7:1]};
        8'h13: begin
          acc   <= {carry, acc[7:1]};
          carry <= acc[0];
        end
        8'hC4: acc <= {acc[3:0], acc[7:4]};
        8'hE4: acc <= ocd_pkg::ACC_RST;
        8'hF4: acc <= ~acc;
        8'h04: acc <= acc + 8'h01;
        8'h14: acc <= acc - 8'h01;
        8'b1101_011?: acc <= {acc[7:4], ind_data[3:0]};
        default: acc <= acc;
      endcase
    end else if (acc_load) begin
      acc <= acc_in;
    end
  end

  // Memory side of the low nibble exchange, written in the last cycle
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      nib_wdata <= ocd_pkg::ACC_RST;
      nib_we    <= 1'b0;
    end else begin
      if (accept && dec_now.cls == ocd_pkg::OCD_NIBBLE) begin
        nib_wdata <= {ind_data[7:4], acc[3:0]};
      end
      nib_we <= next_cnt == ocd_pkg::CNT_LAST &&
                (accept ? dec_now.cls : held.cls) == ocd_pkg::OCD_NIBBLE;
    end
  end

endmodule

// *** sim/ocd_decode_sva.sv ***
/*
  Checker for the opcode decoder: take handshake, instruction length in
  clocks and accumulator effects.
  Assumes it is bound to ocd_decode and sees only its ports.
*/
`timescale 1ns/1ps

module ocd_decode_sva (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_b,
  // Opcode fetch
  input wire logic              op_valid,
  input wire logic [7:0]        opcode,
  // Decoder outputs
  input wire ocd_pkg::ocd_dec_s dec_info,
  input wire logic              busy,
  input wire logic              last_cycle,
  input wire logic [7:0]        acc,
  input wire logic              nib_we
);
  logic       take;
  logic [4:0] cnt;

  assign take = op_valid && (!busy || last_cycle);

  // Cycles spent in the current instruction
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 5'h00;
    end else if (take) begin
      cnt <= 5'h01;
    end else if (busy) begin
      cnt <= cnt + 5'h01;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  take_busy_a: assert property (take |=> busy)
    else $error("busy missing after take");
  cycle_len_a: assert property (last_cycle |-> cnt == dec_info.cyc)
    else $error("instruction length differs from cycle count");
  swap_len_a: assert property (take && opcode == 8'hC4 |=>
    dec_info.cyc == 5'h04 && dec_info.len == 2'h1)
    else $error("nibble swap length wrong");
  code_read_a: assert property (take && opcode == 8'h83 |=>
    dec_info.cyc == 5'h08) else $error("code read cycles wrong");
  xdata_len_a: assert property (take && opcode == 8'hE0 |=>
    dec_info.cyc == 5'h06) else $error("external read cycles wrong");
  nib_pulse_a: assert property (take && opcode == 8'hD6 |-> ##4 nib_we)
    else $error("write-back pulse not in fourth cycle");
  nib_end_a: assert property (nib_we |-> last_cycle)
    else $error("write-back pulse outside last cycle");
  rot_left_a: assert property (take && opcode == 8'h23 |=>
    acc == 8'({$past(acc), $past(acc)} >> 7))
    else $error("left rotate result wrong");
  hold_dec_a: assert property (busy && !last_cycle |=>
    $stable(dec_info))
    else $error("decode changed mid instruction");
  end_busy_a: assert property (last_cycle && !take |=> !busy)
    else $error("busy past last cycle");

  cover property (take && opcode == 8'h84);
  cover property (last_cycle && take);
  cover property (nib_we);
endmodule

bind ocd_decode ocd_decode_sva chk_u (
  .ref_clk    (ref_clk),
  .rst_b      (rst_b),
  .op_valid   (op_valid),
  .opcode     (opcode),
  .dec_info   (dec_info),
  .busy       (busy),
  .last_cycle (last_cycle),
  .acc        (acc),
  .nib_we     (nib_we)
);

// *** sim/ocd_fetch_model.sv ***
/*
  Fetch and data memory model: presents opcodes and the indirect byte.
  Assumes its tasks are called at a falling edge of ref_clk.
*/
`timescale 1ns/1ps

module ocd_fetch_model (
  // Clock and decoder status
  input wire logic ref_clk,
  input wire logic busy,
  input wire logic last_cycle,
  // Opcode and operand byte
  output logic       op_valid,
  output logic [7:0] opcode,
  output logic [7:0] ind_data,
  // Opcode never taken
  output logic       hang
);
  realtime t_take;

  initial begin
    op_valid = 1'b0;
    opcode = 8'h00;
    ind_data = 8'h00;
    hang = 1'b0;
    t_take = 0;
  end

  // Holds the opcode until taken; returns at the falling edge after
  task automatic issue(input logic [7:0] op, input logic [7:0] nd);
    int n;
    n = 0;
    op_valid = 1'b1;
    opcode = op;
    ind_data = nd;
    while (busy && !last_cycle && n < 40) begin
      n++;
      @(negedge ref_clk);
    end
    if (n == 40) hang = 1'b1;
    @(posedge ref_clk);
    t_take = $realtime;
    @(negedge ref_clk);
  endtask

  // Released operand lines no longer show the old byte
  task automatic idle();
    op_valid = 1'b0;
    ind_data = ~ind_data;
  endtask
endmodule

// *** sim/ocd_decode_bench.sv ***
/*
  Self-checking bench for the opcode decoder: length, cycles, spacing
  and accumulator effects. Assumes the fetch model in ocd_fetch_model.
*/
`timescale 1ns/1ps

module ocd_decode_bench;
  logic              ref_clk, rst_b, wide_operand, acc_load, op_valid;
  logic              busy, last_cycle, carry, nib_we, hang;
  logic [7:0]        opcode, acc_in, ind_data, acc, nib_wdata;
  ocd_pkg::ocd_dec_s dec_info;
  int                fail_count, n_compared;
  realtime           prev_t;
  logic [4:0]        prev_c;

  ocd_decode dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid),
    .opcode(opcode), .wide_operand(wide_operand), .acc_load(acc_load),
    .acc_in(acc_in), .ind_data(ind_data), .dec_info(dec_info),
    .busy(busy), .last_cycle(last_cycle), .acc(acc), .carry(carry),
    .nib_wdata(nib_wdata), .nib_we(nib_we));

  ocd_fetch_model fm (.ref_clk(ref_clk), .busy(busy),
    .last_cycle(last_cycle), .op_valid(op_valid), .opcode(opcode),
    .ind_data(ind_data), .hang(hang));

  always #50 ref_clk = ~ref_clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Back-to-back issue; spacing to the previous take must equal its cycles
  task automatic step(input logic [7:0] op, input logic [1:0] l,
                      input logic [4:0] c);
    int spc;
    fm.issue(op, 8'h3C);
    spc = int'((fm.t_take - prev_t) / 100.0);
    check(8'(dec_info.known), 8'h01, "known");
    check(8'(dec_info.len), 8'(l), "len");
    check(8'(dec_info.cyc), 8'(c), "cyc");
    if (prev_c != 5'h00) check(8'(spc), 8'(prev_c), "spacing");
    prev_t = fm.t_take;
    prev_c = c;
  endtask

  task automatic drain();
    int n;
    n = 0;
    fm.idle();
    while (busy !== 1'b0 && n < 40) begin
      n++;
      @(negedge ref_clk);
    end
    prev_c = 5'h00;
    if (n == 40) begin
      fail_count++;
      results();
    end
  endtask

  task automatic acc_chk(input logic [7:0] a, input logic cy);
    check(acc, a, "acc");
    check(8'(carry), 8'(cy), "carry");
  endtask

  task automatic cls_chk(input ocd_pkg::ocd_class_e k);
    check(8'(dec_info.cls), 8'(k), "class");
  endtask

  task automatic decode_arith();
    step(8'h28, 2'h1, 5'h01);
    cls_chk(ocd_pkg::OCD_ARITH);
    step(8'h26, 2'h1, 5'h02);
    step(8'h24, 2'h2, 5'h02);
    step(8'h3F, 2'h1, 5'h01);
    step(8'h35, 2'h2, 5'h02);
    step(8'h97, 2'h1, 5'h02);
    step(8'h94, 2'h2, 5'h02);
    step(8'h0F, 2'h1, 5'h02);
    step(8'h05, 2'h2, 5'h03);
    step(8'h16, 2'h1, 5'h03);
    step(8'hA3, 2'h1, 5'h04);
    step(8'hD4, 2'h1, 5'h01);
    // Opcode outside the table: reported unknown, one byte, one cycle
    fm.issue(8'h00, 8'h3C);
    check(8'(dec_info.known), 8'h00, "unlisted known");
    check(8'(dec_info.len), 8'h01, "unlisted len");
    check(8'(dec_info.cyc), 8'h01, "unlisted cyc");
    cls_chk(ocd_pkg::OCD_OTHER);
    drain();
  endtask

  task automatic decode_logic();
    step(8'h5F, 2'h1, 5'h01);
    cls_chk(ocd_pkg::OCD_LOGIC);
    step(8'h55, 2'h2, 5'h02);
    step(8'h53, 2'h3, 5'h03);
    step(8'h47, 2'h1, 5'h02);
    step(8'h42, 2'h2, 5'h03);
    step(8'h43, 2'h3, 5'h03);
    step(8'h66, 2'h1, 5'h02);
    step(8'h62, 2'h2, 5'h03);
    step(8'hF4, 2'h1, 5'h01);
    drain();
  endtask

  task automatic decode_move();
    step(8'hEF, 2'h1, 5'h01);
    cls_chk(ocd_pkg::OCD_MOVE);
    step(8'h74, 2'h2, 5'h02);
    step(8'hF8, 2'h1, 5'h02);
    step(8'hAF, 2'h2, 5'h03);
    step(8'h88, 2'h2, 5'h02);
    step(8'h86, 2'h2, 5'h03);
    step(8'h85, 2'h3, 5'h03);
    step(8'hF7, 2'h1, 5'h02);
    step(8'hA6, 2'h2, 5'h03);
    step(8'h90, 2'h3, 5'h03);
    step(8'hC8, 2'h1, 5'h03);
    cls_chk(ocd_pkg::OCD_EXCH);
    step(8'hC5, 2'h2, 5'h04);
    drain();
  endtask

  task automatic decode_long();
    step(8'hA4, 2'h1, 5'h0B);
    cls_chk(ocd_pkg::OCD_MULDIV);
    wide_operand = 1'b1;
    step(8'h84, 2'h1, 5'h14);
    wide_operand = 1'b0;
    step(8'h93, 2'h1, 5'h07);
    cls_chk(ocd_pkg::OCD_CODE_READ);
    step(8'h83, 2'h1, 5'h08);
    step(8'hE3, 2'h1, 5'h05);
    cls_chk(ocd_pkg::OCD_XDATA);
    step(8'hE0, 2'h1, 5'h06);
    step(8'hF2, 2'h1, 5'h04);
    step(8'hF0, 2'h1, 5'h05);
    step(8'hC0, 2'h2, 5'h05);
    cls_chk(ocd_pkg::OCD_STACK);
    step(8'hD0, 2'h2, 5'h04);
    drain();
  endtask

  task automatic acc_ops();
    // Accumulator holds FF from the earlier complement; clear it
    step(8'hE4, 2'h1, 5'h01);
    acc_chk(8'h00, 1'b0);
    drain();
    acc_load = 1'b1;
    acc_in = 8'hA5;
    @(negedge ref_clk);
    acc_load = 1'b0;
    step(8'h23, 2'h1, 5'h01);
    cls_chk(ocd_pkg::OCD_ROTATE);
    acc_chk(8'h4B, 1'b0);
    step(8'h33, 2'h1, 5'h01);
    acc_chk(8'h96, 1'b0);
    step(8'h33, 2'h1, 5'h01);
    acc_chk(8'h2C, 1'b1);
    step(8'h13, 2'h1, 5'h01);
    acc_chk(8'h96, 1'b0);
    step(8'h03, 2'h1, 5'h01);
    acc_chk(8'h4B, 1'b0);
    step(8'hC4, 2'h1, 5'h04);
    acc_chk(8'hB4, 1'b0);
    step(8'h04, 2'h1, 5'h01);
    acc_chk(8'hB5, 1'b0);
    step(8'h14, 2'h1, 5'h01);
    acc_chk(8'hB4, 1'b0);
    step(8'hF4, 2'h1, 5'h01);
    acc_chk(8'h4B, 1'b0);
    step(8'hF4, 2'h1, 5'h01);
    acc_chk(8'hB4, 1'b0);
    drain();
  endtask

  // Low nibble exchange with operand byte 3C; write-back in cycle four
  task automatic nibble_xchg();
    step(8'hD6, 2'h1, 5'h04);
    cls_chk(ocd_pkg::OCD_NIBBLE);
    acc_chk(8'hBC, 1'b0);
    fm.idle();
    repeat (3) @(negedge ref_clk);
    check(8'(nib_we), 8'h01, "write-back pulse");
    check(nib_wdata, 8'h34, "write-back byte");
    check(8'(last_cycle), 8'h01, "last cycle");
    @(negedge ref_clk);
    check(8'(nib_we), 8'h00, "pulse end");
    check(8'(busy), 8'h00, "busy end");
    prev_c = 5'h00;
  endtask

  always @(posedge hang) begin
    fail_count++;
    results();
  end

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    wide_operand = 1'b0;
    acc_load = 1'b0;
    acc_in = 8'h00;
    fail_count = 0;
    n_compared = 0;
    prev_t = 0;
    prev_c = 5'h00;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    check(acc, 8'h00, "reset acc");
    decode_arith();
    decode_logic();
    decode_move();
    decode_long();
    acc_ops();
    nibble_xchg();
    results();
  end
endmodule
